// ===== odc_pkg.sv
// package: constants for the octal driver serial command block
package odc_pkg;
    localparam int          ODC_CH        = 8;
    localparam int          ODC_WORD      = 16;
    localparam logic [15:0] ODC_CMD_RESET = 16'hFFFF;
    localparam logic [15:0] ODC_DIAG_RESET = 16'h0000;
    localparam logic [7:0]  ODC_CNT_RESET = 8'h00;
    localparam logic [7:0]  ODC_CNT_MIN   = 8'h10;
    localparam logic [1:0]  ODC_CODE_STBY = 2'h0;
    localparam logic [1:0]  ODC_CODE_PAR  = 2'h1;
    localparam logic [1:0]  ODC_CODE_ON   = 2'h2;
    localparam logic [1:0]  ODC_CODE_OFF  = 2'h3;
endpackage

// ===== odc_core.sv
// module: serial command interpreter and fault reporting for eight low-side channels
`timescale 1ns/1ns
//
// Behaviour
// - two command bits per channel, channel eight top
// - code 00: standby, off, clear faults
// - code 01: follow parallel pin, diag current
// - 10 on no diag; 11 off diag, none before first valid frame
// - first 16-bit word of each frame shifts diagnostics out
// - serial output carries error ORed with input, diagnostics, then chained input
// - error flag shown from select until clock
// - leaving limp-home or undervoltage sets error
// - open-load flags at odd bits
// - overload/overtemp flags at even bits
// - open-load detect only off and enabled
// - open-load stays latched until serial clear or limp-home
// - open-load never blocks turning on
// - short to ground uses open-load path
// - no separate short-to-battery fault memory
// - overload latches off until serial clear or limp-home
// - overtemp latches off until serial clear or limp-home
// - msb first, sample falling, shift rising
// - count clocks; frame valid multiple eight, min16
// - reset presets all command bits high
// - valid frame clears error flag
module odc_core
    import odc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        spi_clk,
    input  wire logic        chip_select_low,
    input  wire logic        spi_din,
    output logic             spi_dout,
    input  wire logic [7:0]  parallel_control_pin,
    input  wire logic        limp_home_input,
    input  wire logic        undervoltage,
    input  wire logic [7:0]  open_load_sense,
    input  wire logic [7:0]  overload_sense,
    input  wire logic [7:0]  overtemp_sense,
    output logic      [7:0]  drive_on,
    output logic      [7:0]  diag_current_en,
    output logic      [15:0] channel_command_q
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers, two flops each
    logic [2:0]  lnk_s1_q, lnk_s2_q;
    logic [25:0] sen_s1_q, sen_s2_q;
    logic [7:0]  par_s1_q, par_s2_q;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lnk_s1_q <= 3'h2; // idle link: clock low, deselected, data low
            lnk_s2_q <= 3'h2;
            sen_s1_q <= 26'h0;
            sen_s2_q <= 26'h0;
            par_s1_q <= 8'h00;
            par_s2_q <= 8'h00;
        end
        else
        begin
            lnk_s1_q <= {spi_clk, chip_select_low, spi_din};
            lnk_s2_q <= lnk_s1_q;
            sen_s1_q <= {limp_home_input, undervoltage, open_load_sense, overload_sense, overtemp_sense};
            sen_s2_q <= sen_s1_q;
            par_s1_q <= parallel_control_pin;
            par_s2_q <= par_s1_q;
        end
    end

    logic sclk_s, cs_s, din_s;
    assign sclk_s = lnk_s2_q[2];
    assign cs_s   = lnk_s2_q[1];
    assign din_s  = lnk_s2_q[0];

    // edge detection on synchronised link, limp-home and undervoltage signals
    logic sclk_d1_q, cs_d1_q, lhi_d1_q, uv_d1_q;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_d1_q <= 1'b0;
            cs_d1_q   <= 1'b1;
            lhi_d1_q  <= 1'b0;
            uv_d1_q   <= 1'b0;
        end
        else
        begin
            sclk_d1_q <= sclk_s;
            cs_d1_q   <= cs_s;
            lhi_d1_q  <= sen_s2_q[25];
            uv_d1_q   <= sen_s2_q[24];
        end
    end

    logic sclk_rise, sclk_fall, cs_fall, cs_rise, lhi_exit, uv_exit;
    assign sclk_rise = sclk_s & ~sclk_d1_q & ~cs_s;
    assign sclk_fall = ~sclk_s & sclk_d1_q & ~cs_s;
    assign cs_fall   = ~cs_s & cs_d1_q;
    assign cs_rise   = cs_s & ~cs_d1_q;
    assign lhi_exit  = ~sen_s2_q[25] & lhi_d1_q;
    assign uv_exit   = ~sen_s2_q[24] & uv_d1_q;

    logic [7:0] ol_in, ovl_in, ot_in;
    assign ol_in  = sen_s2_q[23:16];
    assign ovl_in = sen_s2_q[15:8];
    assign ot_in  = sen_s2_q[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // frame reception: bit counter and input shifter
    logic [7:0]  bit_cnt_q;
    logic [15:0] rx_q;
    logic        frame_ok;
    assign frame_ok = (bit_cnt_q[2:0] == 3'h0) && (bit_cnt_q >= ODC_CNT_MIN);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt_q <= ODC_CNT_RESET;
            rx_q      <= 16'h0000;
        end
        else if (cs_fall)
            bit_cnt_q <= ODC_CNT_RESET;
        else if (sclk_fall)
        begin
            rx_q <= {rx_q[14:0], din_s};
            // saturate at an invalid count so long chains never look framed
            bit_cnt_q <= (bit_cnt_q == 8'hFF) ? 8'hFF : bit_cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command register, latched only on a valid frame
    logic cmd_load;
    logic por_q;
    assign cmd_load = cs_rise & frame_ok;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            channel_command_q <= ODC_CMD_RESET;
            por_q             <= 1'b1;
        end
        else if (cmd_load)
        begin
            channel_command_q <= rx_q;
            por_q             <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame error flag
    logic frame_error_flag_q;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            frame_error_flag_q <= 1'b1;
        else if (lhi_exit || uv_exit)
            frame_error_flag_q <= 1'b1;
        else if (cs_rise)
            frame_error_flag_q <= ~frame_ok;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel decode and fault latches
    logic [7:0]  ol_flag_q;
    logic [7:0]  overload_overtemp_flag_q;
    logic [15:0] fault_diagnostic;

    genvar gi;
    generate
        for (gi = 0; gi < ODC_CH; gi++)
        begin : g_ch
            logic [1:0] code;
            logic       want_on, clr;
            assign code = channel_command_q[2*gi+1 -: 2];
            assign want_on = (code == ODC_CODE_ON) || (code == ODC_CODE_PAR && par_s2_q[gi]);
            assign clr = (code == ODC_CODE_STBY) || sen_s2_q[25];
            // latched fault blocks, open load not
            assign drive_on[gi] = want_on & ~overload_overtemp_flag_q[gi] & ~sen_s2_q[25];
            assign diag_current_en[gi] = ~drive_on[gi] &
                ((code == ODC_CODE_PAR) || (code == ODC_CODE_OFF && !por_q));

            always_ff @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    ol_flag_q[gi]                <= 1'b0;
                    overload_overtemp_flag_q[gi] <= 1'b0;
                end
                else if (clr)
                begin
                    ol_flag_q[gi]                <= 1'b0;
                    overload_overtemp_flag_q[gi] <= 1'b0;
                end
                else
                begin
                    // open load or short to ground
                    if (ol_in[gi] && diag_current_en[gi])
                        ol_flag_q[gi] <= 1'b1;
                    if ((ovl_in[gi] && drive_on[gi]) || ot_in[gi])
                        overload_overtemp_flag_q[gi] <= 1'b1;
                end
            end
            assign fault_diagnostic[2*gi+1] = ol_flag_q[gi];
            assign fault_diagnostic[2*gi]   = overload_overtemp_flag_q[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // reply shifter and serial output
    logic [15:0] tx_q;
    logic        ter_phase_q;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_q        <= ODC_DIAG_RESET;
            ter_phase_q <= 1'b0;
        end
        else if (cs_fall)
        begin
            tx_q        <= fault_diagnostic;
            ter_phase_q <= 1'b1;
        end
        else if (sclk_rise)
        begin
            ter_phase_q <= 1'b0;
            // shift on rising edge, chaining input
            if (!ter_phase_q)
                tx_q <= {tx_q[14:0], din_s};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            spi_dout <= 1'b0;
        else if (cs_s)
            spi_dout <= 1'b0;
        else if (cs_fall || (ter_phase_q && !sclk_rise))
            spi_dout <= frame_error_flag_q | din_s; // no stale shifter bit at select fall
        else
            spi_dout <= (sclk_rise && !ter_phase_q) ? tx_q[14] : tx_q[15];
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // reset preset
    cmd_preset_a: assert property (@(posedge sys_clk) $rose(nrst) |-> channel_command_q == ODC_CMD_RESET)
        else $error("command not preset");
    bad_frame_a: assert property (@(posedge sys_clk) disable iff (!nrst) (cs_rise && !frame_ok) |=> $stable(channel_command_q))
        else $error("bad frame loaded");
    err_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) (cs_rise && frame_ok && !lhi_exit && !uv_exit) |=> !frame_error_flag_q)
        else $error("error not cleared");
    err_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst) (lhi_exit || uv_exit) |=> frame_error_flag_q)
        else $error("error not set on exit");
    ovl_latch_a: assert property (@(posedge sys_clk) disable iff (!nrst) (overload_overtemp_flag_q[0]) |-> !drive_on[0])
        else $error("channel on with fault");
    stby_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) (channel_command_q[1:0] == ODC_CODE_STBY) |-> (!drive_on[0] ##1 (ol_flag_q[0] == 1'b0 && overload_overtemp_flag_q[0] == 1'b0)))
        else $error("standby not clearing");
    on_code_a: assert property (@(posedge sys_clk) disable iff (!nrst) (channel_command_q[15:14] == ODC_CODE_ON && !overload_overtemp_flag_q[7] && !sen_s2_q[25]) |-> (drive_on[7] && !diag_current_en[7]))
        else $error("on code wrong");
    sequence sel_fall_s; cs_fall; endsequence
    diag_snap_a: assert property (@(posedge sys_clk) disable iff (!nrst) sel_fall_s |=> tx_q == $past(fault_diagnostic))
        else $error("snapshot missed");
    // error flag first at select fall
    ter_first_a: assert property (@(posedge sys_clk) disable iff (!nrst) sel_fall_s |=> spi_dout == ($past(frame_error_flag_q) | $past(din_s)))
        else $error("error flag not shown at select");
    ol_noblock_a: assert property (@(posedge sys_clk) disable iff (!nrst) (channel_command_q[5:4] == ODC_CODE_ON && !overload_overtemp_flag_q[2] && !sen_s2_q[25]) |-> drive_on[2])
        else $error("open load blocked channel");
    ol_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst) (ol_flag_q[3] && channel_command_q[7:6] != ODC_CODE_STBY && !sen_s2_q[25]) |=> ol_flag_q[3])
        else $error("open load dropped");

endmodule

// ===== odc_spi_master.sv
// spi master model that sends command frames and collects the reply
`timescale 1ns/1ns
module odc_spi_master
    import odc_pkg::*;
(
    input  wire logic sys_clk,
    output logic      spi_clk,
    output logic      chip_select_low,
    output logic      spi_din,
    input  wire logic spi_dout
);
    // idle: deselected, clock low
    initial
    begin
        spi_clk = 1'b0;
        chip_select_low = 1'b1;
        spi_din = 1'b0;
    end

    // half spi period of 32 ns, moves on the falling system edge
    task automatic half();
        repeat (8) @(negedge sys_clk);
    endtask

    task automatic xfer(input int nbits, input logic [23:0] word, output logic err, output logic [15:0] reply);
        reply = 16'h0000;
        spi_din = 1'b0; // low input for clean error readout
        chip_select_low = 1'b0;
        half();
        err = spi_dout;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            spi_din = word[i];
            spi_clk = 1'b1;
            half();
            if (i >= nbits - 16)
                reply = {reply[14:0], spi_dout};
            spi_clk = 1'b0;
            half();
        end
        chip_select_low = 1'b1;
        spi_din = ~spi_din; // released line shows no stale bit
        half();
    endtask
endmodule

// ===== tb_octal_driver_spi_command_status.sv
// self-checking bench for the serial command and fault reporting block
`timescale 1ns/1ns
module tb_octal_driver_spi_command_status
    import odc_pkg::*;
;
    logic        sys_clk;
    logic        nrst;
    logic        spi_clk;
    logic        chip_select_low;
    logic        spi_din;
    logic        spi_dout;
    logic [7:0]  parallel_control_pin;
    logic        limp_home_input;
    logic        undervoltage;
    logic [7:0]  open_load_sense;
    logic [7:0]  overload_sense;
    logic [7:0]  overtemp_sense;
    logic [7:0]  drive_on;
    logic [7:0]  diag_current_en;
    logic [15:0] channel_command_q;
    int          n_errors = 0;
    int          n_compared = 0;
    int          cycles = 0;

    odc_core odc_core_inst (.sys_clk(sys_clk), .nrst(nrst), .spi_clk(spi_clk),
        .chip_select_low(chip_select_low), .spi_din(spi_din), .spi_dout(spi_dout),
        .parallel_control_pin(parallel_control_pin), .limp_home_input(limp_home_input),
        .undervoltage(undervoltage), .open_load_sense(open_load_sense), .overload_sense(overload_sense),
        .overtemp_sense(overtemp_sense), .drive_on(drive_on), .diag_current_en(diag_current_en),
        .channel_command_q(channel_command_q));

    odc_spi_master odc_spi_master_inst (.sys_clk(sys_clk), .spi_clk(spi_clk),
        .chip_select_low(chip_select_low), .spi_din(spi_din), .spi_dout(spi_dout));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare, frame and output helpers
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic frame(input int nbits, input logic [23:0] word, input logic e_err, input logic [15:0] e_rep);
        logic        err;
        logic [15:0] rep;
        odc_spi_master_inst.xfer(nbits, word, err, rep);
        check("error flag", {15'h0000, err}, {15'h0000, e_err});
        if (nbits >= 16)
            check("reply", rep, e_rep);
    endtask

    task automatic outs(input logic [15:0] cmd, input logic [7:0] drv, input logic [7:0] dia);
        repeat (4) @(negedge sys_clk);
        check("command", channel_command_q, cmd);
        check("drive", {8'h00, drive_on}, {8'h00, drv});
        check("diag current", {8'h00, diag_current_en}, {8'h00, dia});
    endtask

    task automatic pulse(input logic limp);
        undervoltage = ~limp;
        limp_home_input = limp;
        repeat (10) @(negedge sys_clk);
        undervoltage = 1'b0;
        limp_home_input = 1'b0;
        repeat (10) @(negedge sys_clk);
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        nrst = 1'b0;
        parallel_control_pin = 8'h02;
        limp_home_input = 1'b0;
        undervoltage = 1'b0;
        open_load_sense = 8'h00;
        overload_sense = 8'h00;
        overtemp_sense = 8'h00;
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        outs(ODC_CMD_RESET, 8'h00, 8'h00);
        frame(16, 24'h00B4B4, 1'b1, ODC_DIAG_RESET);
        outs(16'hB4B4, 8'h8A, 8'h64);
        frame(12, 24'h000000, 1'b0, 16'h0000);
        outs(16'hB4B4, 8'h8A, 8'h64);
        frame(8, 24'h0000FF, 1'b1, 16'h0000);
        frame(24, 24'hFFB4B4, 1'b1, 16'h0000);
        outs(16'hB4B4, 8'h8A, 8'h64);
        open_load_sense = 8'h0C;
        overload_sense = 8'h08;
        overtemp_sense = 8'h80;
        repeat (20) @(negedge sys_clk);
        open_load_sense = 8'h00;
        overload_sense = 8'h00;
        overtemp_sense = 8'h00;
        repeat (4) @(negedge sys_clk);
        check("drive", {8'h00, drive_on}, 16'h0002);
        frame(16, 24'h00B4A4, 1'b0, 16'h4060);
        check("drive", {8'h00, drive_on}, 16'h0006);
        frame(16, 24'h000000, 1'b0, 16'h4060);
        check("drive", {8'h00, drive_on}, 16'h0000);
        frame(16, 24'h00B4B4, 1'b0, ODC_DIAG_RESET);
        outs(16'hB4B4, 8'h8A, 8'h64);
        parallel_control_pin = 8'h20;
        outs(16'hB4B4, 8'hA8, 8'h46);
        pulse(1'b0);
        frame(16, 24'h00B4B4, 1'b1, ODC_DIAG_RESET);
        frame(16, 24'h00B4B4, 1'b0, ODC_DIAG_RESET);
        pulse(1'b1);
        frame(16, 24'h00B4B4, 1'b1, ODC_DIAG_RESET);
        finish_test();
    end
endmodule
